/* core/cat_pkg.sv */
// Shared types and constants for the capture, trigger and exposure sequencer.
package cat_pkg;
  // Clock and time base.
  localparam int CLK_PERIOD_NS = 10;
  localparam int USEC_NS = 1000;
  localparam int CYC_PER_US = USEC_NS / CLK_PERIOD_NS;
  localparam int PRESCALE_W = 7;
  localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_W'(CYC_PER_US - 1);
  // Exposure limits in microseconds.
  localparam int EXP_W = 21;
  localparam logic [EXP_W-1:0] EXP_MIN_US = 21'h00_000A;
  localparam logic [EXP_W-1:0] EXP_MAX_US = 21'h1E_83BE;
  // Trigger delay, frame period and burst count widths.
  localparam int DELAY_W = 16;
  localparam int PERIOD_W = 20;
  localparam int BURST_W = 8;
  // Trigger selector entries and functions ranked for the polarity default.
  localparam int SEL_ENTRIES = 6;
  localparam int FUNC_MAIN = 4;
  localparam int FUNC_AUX = 4;
  localparam int FN_BEGIN = 0;
  localparam int FN_FINISH = 1;
  localparam int FN_FRAME = 2;
  localparam int FN_RELEASE = 3;
  localparam int LINES = 2;
  // Reset values.
  localparam logic RST_POLARITY = 1'b1;

  typedef enum logic [1:0] {
    SENSE_RISE = 2'h0,
    SENSE_FALL = 2'h1,
    SENSE_HIGH = 2'h2,
    SENSE_LOW = 2'h3
  } cat_sense_t;

  typedef enum logic [1:0] {
    SRC_OFF = 2'h0,
    SRC_LINE0 = 2'h1,
    SRC_LINE1 = 2'h2,
    SRC_HOST = 2'h3
  } cat_src_t;

  typedef enum logic [1:0] {
    INTEG_OFF = 2'h0,
    INTEG_PRESET = 2'h1,
    INTEG_PULSE = 2'h2
  } cat_integ_t;

  typedef enum logic [1:0] {
    INIT_AUTO = 2'h0,
    INIT_RISE = 2'h1,
    INIT_FALL = 2'h2
  } cat_init_t;

  typedef enum logic [2:0] {
    PICK_CAP_WAIT = 3'h0,
    PICK_CAP_ON = 3'h1,
    PICK_CAP_MOVE = 3'h2,
    PICK_FRM_WAIT = 3'h3,
    PICK_FRM_OPEN = 3'h4,
    PICK_FRM_MOVE = 3'h5,
    PICK_EXPOSE = 3'h6,
    PICK_HOLD = 3'h7
  } cat_pick_t;

  typedef enum logic [1:0] {
    CAP_IDLE = 2'b00,
    CAP_WAIT = 2'b01,
    CAP_ON = 2'b11
  } cat_cap_t;

  typedef enum logic [2:0] {
    EX_IDLE = 3'b000,
    EX_DELAY = 3'b001,
    EX_ALIGN = 3'b011,
    EX_EXPOSE = 3'b010
  } cat_exp_t;

  // Per-function trigger setup.
  typedef struct packed {
    logic use_trig;
    cat_src_t src;
    cat_sense_t sense;
  } cat_trig_cfg_t;

  // Status view, one bit per selectable item.
  typedef struct packed {
    logic capture_arm_waiting;
    logic capture_allowed;
    logic capture_moving_data;
    logic frame_arm_waiting;
    logic frame_window_open;
    logic frame_moving_data;
    logic light_integration_on;
    logic stream_hold_waiting;
  } cat_status_t;
endpackage : cat_pkg

/* core/cat_trig_detect.sv */
// Edge or level detection of one trigger function on an already synchronised source.
`timescale 1ns/10ps
module cat_trig_detect
  import cat_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_level,
  input wire logic i_use_host,
  input wire logic i_host_pulse,
  input wire cat_sense_t i_sense,
  output logic o_fire,
  output logic o_active
);
  typedef struct packed {
    logic prev;
  } cat_det_state_t;

  cat_det_state_t st;
  cat_det_state_t next_st;
  logic lvl_on;

  // Level is active when it matches the chosen high or low sense.
  always_comb begin
    next_st.prev = i_level;
    lvl_on = (i_sense == SENSE_LOW) ? ~i_level : i_level;
    o_active = i_use_host ? i_host_pulse : lvl_on;
    case (i_sense)
      SENSE_RISE: o_fire = i_level & ~st.prev;
      SENSE_FALL: o_fire = ~i_level & st.prev;
      SENSE_HIGH: o_fire = i_level & ~st.prev;
      SENSE_LOW: o_fire = ~i_level & st.prev;
      default: o_fire = 1'b0;
    endcase
    // A host command only counts when the entry points at the host.
    if (i_use_host) begin
      o_fire = i_host_pulse;
    end
  end

  // Previous sample for edge detection.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  a_rise_fire: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (!i_use_host && i_sense == SENSE_RISE && o_fire) |-> (i_level && !$past(i_level)))
    else $error("Rise fire without a rising level");
endmodule // cat_trig_detect

/* core/cat_seq.sv */
// Capture, trigger and exposure sequencer of the camera.
`timescale 1ns/10ps
module cat_seq
  import cat_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [LINES-1:0] i_trig_line,
  input wire logic [SEL_ENTRIES-1:0] i_host_trig,
  input wire cat_trig_cfg_t [FUNC_MAIN-1:0] i_trig_cfg,
  input wire cat_sense_t [FUNC_AUX-1:0] i_aux_sense,
  input wire logic [FUNC_AUX-1:0] i_aux_on_line0,
  input wire cat_init_t i_initial_sense,
  input wire logic i_capture_begin_cmd,
  input wire logic i_capture_finish_cmd,
  input wire logic i_burst_mode,
  input wire logic [BURST_W-1:0] i_burst_frame_total,
  input wire cat_integ_t i_integration_style,
  input wire logic [2:0][EXP_W-1:0] i_integration_length,
  input wire logic [DELAY_W-1:0] i_trigger_delay_us,
  input wire logic [PERIOD_W-1:0] i_frame_period_us,
  input wire logic i_readout_overlap_policy,
  input wire logic i_readout_busy,
  input wire logic i_line_start,
  input wire logic i_stream_done,
  input wire cat_pick_t i_capture_status_pick,
  output cat_status_t o_status,
  output logic o_status_bit,
  output logic o_exposure_end,
  output logic o_stream_start,
  output logic o_input_polarity
);
  typedef struct packed {
    logic [LINES-1:0] sync1;
    logic [LINES-1:0] sync2;
    cat_cap_t cap;
    cat_exp_t ex;
    logic [PRESCALE_W-1:0] pre;
    logic [EXP_W-1:0] us_cnt;
    logic [PERIOD_W-1:0] frm_cnt;
    logic stored;
    logic streaming;
    logic [BURST_W-1:0] sent;
    logic polarity;
    logic init_done;
    logic exp_end;
    logic strm_go;
    cat_status_t status;
  } cat_state_t;

  cat_state_t st;
  cat_state_t next_st;
  logic [FUNC_MAIN-1:0] fire;
  logic [FUNC_MAIN-1:0] active;
  logic [EXP_W-1:0] exp_target;
  logic tick;
  logic frame_req;
  logic trig_mode;
  logic fin_hit;
  logic burst_hit;

  // Longest of the three channel times.
  function automatic logic [EXP_W-1:0] max3(input logic [2:0][EXP_W-1:0] v);
    logic [EXP_W-1:0] m;
    m = (v[0] > v[1]) ? v[0] : v[1];
    return (v[2] > m) ? v[2] : m;
  endfunction

  // Keep the exposure inside the allowed range.
  function automatic logic [EXP_W-1:0] clamp_exp(input logic [EXP_W-1:0] v);
    if (v < EXP_MIN_US) begin
      return EXP_MIN_US;
    end
    return (v > EXP_MAX_US) ? EXP_MAX_US : v;
  endfunction

  // Rise or high sense means a high-active input.
  function automatic logic initial_rise_sense(input cat_sense_t s);
    return (s == SENSE_RISE) || (s == SENSE_HIGH);
  endfunction

  // Sense of the best ranked function that listens to line 0.
  function automatic cat_sense_t top_sense(input cat_trig_cfg_t [FUNC_MAIN-1:0] c,
                                           input cat_sense_t [FUNC_AUX-1:0] a,
                                           input logic [FUNC_AUX-1:0] on);
    cat_sense_t s;
    s = SENSE_RISE;
    for (int k = FUNC_AUX - 1; k >= 0; k--) begin
      if (on[k]) begin
        s = a[k];
      end
    end
    for (int k = FUNC_MAIN - 1; k >= 0; k--) begin
      if (c[k].src == SRC_LINE0) begin
        s = c[k].sense;
      end
    end
    return s;
  endfunction

  // One detector per trigger function, fed from the synchronised lines.
  for (genvar g = 0; g < FUNC_MAIN; g++) begin : g_det
    logic lvl;
    assign lvl = (i_trig_cfg[g].src == SRC_LINE1) ? st.sync2[1] : st.sync2[0];
    cat_trig_detect cat_trig_detect_i (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_level(lvl & (i_trig_cfg[g].src != SRC_OFF)),
      .i_use_host(i_trig_cfg[g].src == SRC_HOST),
      .i_host_pulse(i_host_trig[g]),
      .i_sense(i_trig_cfg[g].sense),
      .o_fire(fire[g]),
      .o_active(active[g])
    );
  end

  // Operation mode and exposure length decode.
  assign trig_mode = i_trig_cfg[FN_FRAME].use_trig && (i_integration_style != INTEG_OFF);
  assign exp_target = (i_integration_style == INTEG_PRESET) ?
                      clamp_exp(max3(i_integration_length)) :
                      EXP_W'(i_frame_period_us);
  assign tick = (st.pre == PRESCALE_LAST);
  assign fin_hit = i_trig_cfg[FN_FINISH].use_trig ? fire[FN_FINISH]
                                                  : i_capture_finish_cmd;
  assign burst_hit = i_burst_mode && (st.sent == i_burst_frame_total) && !st.streaming;
  // Frame request: triggered or self-timed; overlap off drops readout-time triggers.
  assign frame_req = (st.cap == CAP_ON) && (st.ex == EX_IDLE) &&
                     (trig_mode ? fire[FN_FRAME] :
                      (st.frm_cnt >= i_frame_period_us)) &&
                     (!i_readout_busy || i_readout_overlap_policy);

  // Next-state logic for the whole sequencer.
  always_comb begin
    next_st = st;
    next_st.sync1 = i_trig_line;
    next_st.sync2 = st.sync1;
    next_st.pre = tick ? '0 : st.pre + 1'b1;
    next_st.exp_end = 1'b0;
    next_st.strm_go = 1'b0;
    // Capture allowed control.
    case (st.cap)
      CAP_IDLE: begin
        if (i_capture_begin_cmd) begin
          next_st.sent = '0;
          next_st.cap = i_trig_cfg[FN_BEGIN].use_trig ? CAP_WAIT : CAP_ON;
        end
      end
      CAP_WAIT: begin
        if (i_capture_finish_cmd) begin
          next_st.cap = CAP_IDLE;
        end else if (fire[FN_BEGIN]) begin
          next_st.cap = CAP_ON;
        end
      end
      CAP_ON: begin
        if (fin_hit || burst_hit) begin
          next_st.cap = CAP_IDLE;
        end
      end
      default: next_st.cap = CAP_IDLE;
    endcase
    // Self-timed frame period counter.
    if (st.cap != CAP_ON || frame_req) begin
      next_st.frm_cnt = '0;
    end else if (tick && st.frm_cnt < i_frame_period_us) begin
      next_st.frm_cnt = st.frm_cnt + 1'b1;
    end
    // Exposure sequence.
    case (st.ex)
      EX_IDLE: begin
        if (frame_req) begin
          next_st.us_cnt = '0;
          next_st.pre = '0;
          if (trig_mode && i_trigger_delay_us != '0) begin
            next_st.ex = EX_DELAY;
          end else if (i_readout_busy) begin
            next_st.ex = EX_ALIGN;
          end else begin
            next_st.ex = EX_EXPOSE;
          end
        end
      end
      EX_DELAY: begin
        if (tick) begin
          next_st.us_cnt = st.us_cnt + 1'b1;
        end
        if (tick && st.us_cnt + 1'b1 == EXP_W'(i_trigger_delay_us)) begin
          next_st.us_cnt = '0;
          next_st.ex = i_readout_busy ? EX_ALIGN : EX_EXPOSE;
        end
      end
      EX_ALIGN: begin
        if (i_line_start || !i_readout_busy) begin
          next_st.us_cnt = '0;
          next_st.pre = '0;
          next_st.ex = EX_EXPOSE;
        end
      end
      EX_EXPOSE: begin
        if (tick) begin
          next_st.us_cnt = st.us_cnt + 1'b1;
        end
        if ((i_integration_style == INTEG_PULSE && trig_mode) ? !active[FN_FRAME] :
            (tick && st.us_cnt + 1'b1 >= exp_target)) begin
          next_st.ex = EX_IDLE;
          next_st.exp_end = 1'b1;
          next_st.stored = 1'b1;
        end
      end
      default: next_st.ex = EX_IDLE;
    endcase
    // Stream out of the stored frame.
    if (st.streaming && i_stream_done) begin
      next_st.streaming = 1'b0;
    end else if (!st.streaming && st.stored && st.cap == CAP_ON && !burst_hit &&
                 (!i_trig_cfg[FN_RELEASE].use_trig || fire[FN_RELEASE])) begin
      next_st.streaming = 1'b1;
      next_st.strm_go = 1'b1;
      next_st.sent = st.sent + 1'b1;
      if (!next_st.exp_end) begin
        next_st.stored = 1'b0;
      end
    end
    // Input polarity: fixed or automatic choice at start, then tracks level sensing.
    next_st.init_done = 1'b1;
    if (!st.init_done) begin
      case (i_initial_sense)
        INIT_RISE: next_st.polarity = 1'b1;
        INIT_FALL: next_st.polarity = 1'b0;
        default: next_st.polarity = initial_rise_sense(top_sense(i_trig_cfg, i_aux_sense,
                                                        i_aux_on_line0));
      endcase
    end else if (top_sense(i_trig_cfg, i_aux_sense, i_aux_on_line0) == SENSE_HIGH) begin
      next_st.polarity = 1'b1;
    end else if (top_sense(i_trig_cfg, i_aux_sense, i_aux_on_line0) == SENSE_LOW) begin
      next_st.polarity = 1'b0;
    end
    // Status flags, registered.
    next_st.status.capture_arm_waiting = (next_st.cap == CAP_WAIT);
    next_st.status.capture_allowed = (next_st.cap == CAP_ON);
    next_st.status.capture_moving_data = next_st.streaming;
    next_st.status.frame_arm_waiting = (next_st.cap == CAP_ON) && trig_mode &&
                                       (next_st.ex == EX_IDLE);
    next_st.status.frame_window_open = (next_st.ex != EX_IDLE);
    next_st.status.frame_moving_data = i_readout_busy;
    next_st.status.light_integration_on = (next_st.ex == EX_EXPOSE);
    next_st.status.stream_hold_waiting = next_st.stored && !next_st.streaming;
  end

  // State register.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
      st.polarity <= RST_POLARITY;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register.
  assign o_status = st.status;
  assign o_status_bit = st.status[3'h7 - i_capture_status_pick];
  assign o_exposure_end = st.exp_end;
  assign o_stream_start = st.strm_go;
  assign o_input_polarity = st.polarity;

  sequence s_begin_plain;
    (st.cap == CAP_IDLE) && i_capture_begin_cmd && !i_trig_cfg[FN_BEGIN].use_trig;
  endsequence
  sequence s_begin_armed;
    (st.cap == CAP_IDLE) && i_capture_begin_cmd && i_trig_cfg[FN_BEGIN].use_trig;
  endsequence

  a_begin_direct: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    s_begin_plain |=> (st.cap == CAP_ON) ##1 o_status.capture_allowed)
    else $error("Begin without trigger did not allow capture");
  a_begin_waits: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    s_begin_armed |=> (st.cap == CAP_WAIT) ##1 o_status.capture_arm_waiting)
    else $error("Begin with trigger did not wait");
  a_finish_trig: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st.cap == CAP_ON && i_trig_cfg[FN_FINISH].use_trig && fire[FN_FINISH]) |=>
    (st.cap == CAP_IDLE))
    else $error("Finish trigger did not clear capture");
  a_finish_cmd_only: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st.cap == CAP_ON && !i_trig_cfg[FN_FINISH].use_trig && !i_capture_finish_cmd &&
     !burst_hit) |=> (st.cap == CAP_ON))
    else $error("Capture cleared without host command");
  a_overlap_drop: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st.ex == EX_IDLE && i_readout_busy && !i_readout_overlap_policy) |=> (st.ex == EX_IDLE))
    else $error("Trigger accepted during readout with overlap off");
  a_preset_len: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_exposure_end && $past(i_integration_style) == INTEG_PRESET) |->
    ($past(st.ex) == EX_EXPOSE && $past(st.us_cnt) + 1'b1 >= EXP_MIN_US &&
     $past(st.us_cnt) < EXP_MAX_US))
    else $error("Preset exposure ended below minimum");
  a_pulse_hold: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st.ex == EX_EXPOSE && i_integration_style == INTEG_PULSE && trig_mode &&
     active[FN_FRAME]) |=> (st.ex == EX_EXPOSE))
    else $error("Pulse exposure ended while trigger active");
  a_release_gate: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_trig_cfg[FN_RELEASE].use_trig && !fire[FN_RELEASE]) |=> !o_stream_start)
    else $error("Stream started without release trigger");
  a_delay_first: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st.ex == EX_IDLE && frame_req && trig_mode && i_trigger_delay_us != '0) |=>
    (st.ex == EX_DELAY) [*2])
    else $error("Frame trigger delay skipped");
  a_burst_stop: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st.cap == CAP_ON && burst_hit) |=> (st.cap == CAP_IDLE) && !o_status.capture_allowed)
    else $error("Burst did not stop capture");
endmodule // cat_seq

/* bench/cat_trig_src.sv */
// Model of the external trigger lines that feed the sequencer.
`timescale 1ns/10ps
module cat_trig_src (
  output logic [1:0] o_trig_line
);
  // Lines rest low between pulses, as a driver with a pull-down would leave them.
  initial begin
    o_trig_line = 2'b00;
  end

  // One pulse of any width, placed off the clock grid to stress the synchroniser.
  task automatic pulse(input int n, input int width_ns);
    #3;
    o_trig_line[n] = 1'b1;
    #(width_ns);
    o_trig_line[n] = 1'b0;
  endtask
endmodule // cat_trig_src

/* bench/cat_seq_test.sv */
// Self-checking testbench of the capture, trigger and exposure sequencer.
`timescale 1ns/10ps
module cat_seq_test;
  import cat_pkg::*;
  logic clk = 1'b0;
  logic rstn;
  wire [1:0] line;
  logic [9:0] pv;
  cat_trig_cfg_t [FUNC_MAIN-1:0] cfg;
  cat_sense_t [FUNC_AUX-1:0] aux_s;
  cat_init_t init_s;
  logic [FUNC_AUX-1:0] aux_on;
  logic burst, ovl, busy;
  logic [BURST_W-1:0] btot;
  cat_integ_t style;
  logic [2:0][EXP_W-1:0] len;
  logic [DELAY_W-1:0] dly;
  logic [PERIOD_W-1:0] per;
  cat_pick_t pick;
  cat_status_t st;
  logic sbit, xend, sstart, pol;
  int num_errors = 0;
  int checks = 0;
  int starts = 0;
  int ends = 0;

  // Pulse inputs: 5..0 host triggers, 6 begin, 7 finish, 8 line start, 9 stream done.
  cat_seq cat_seq_i (.i_sys_clk(clk), .i_resetn(rstn), .i_trig_line(line),
    .i_host_trig(pv[5:0]), .i_trig_cfg(cfg), .i_aux_sense(aux_s),
    .i_aux_on_line0(aux_on), .i_initial_sense(init_s), .i_capture_begin_cmd(pv[6]),
    .i_capture_finish_cmd(pv[7]), .i_burst_mode(burst), .i_burst_frame_total(btot),
    .i_integration_style(style), .i_integration_length(len),
    .i_trigger_delay_us(dly), .i_frame_period_us(per),
    .i_readout_overlap_policy(ovl), .i_readout_busy(busy), .i_line_start(pv[8]),
    .i_stream_done(pv[9]), .i_capture_status_pick(pick), .o_status(st),
    .o_status_bit(sbit), .o_exposure_end(xend), .o_stream_start(sstart),
    .o_input_polarity(pol));
  cat_trig_src cat_trig_src_i (.o_trig_line(line));

  // The clock toggles every half period of 10 ns.
  always #5 clk = ~clk;

  // Stream starts and exposure ends are counted at every rising edge so no one-cycle pulse is missed.
  always @(posedge clk) begin
    starts += (sstart === 1'b1);
    ends += (xend === 1'b1);
  end

  task automatic wrap_up();
    $display("Checks %0d, errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic pls(input int k);
    pv[k] = 1'b1;
    cyc(1);
    pv[k] = 1'b0;
  endtask

  function automatic logic sig(input int s);
    case (s)
      1: return starts != 0;
      2: return st.light_integration_on;
      3: return st.capture_allowed;
      4: return st.capture_moving_data;
      default: return st.capture_arm_waiting;
    endcase
  endfunction

  // Waits a bounded number of cycles; n equals lim when the value never came.
  task automatic wait_val(input int s, input logic v, input int lim, output int n);
    n = 0;
    while (sig(s) !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic drain();
    int n;
    wait_val(1, 1'b1, 2000, n);
    chk(n < 2000, 1);
    cyc(2);
    chk(st.capture_moving_data, 1'b1);
    pls(9);
    wait_val(4, 1'b0, 5, n);
    chk(n < 5, 1);
    starts = 0;
  endtask

  task automatic t_reset(input cat_init_t s, input logic p);
    rstn = 1'b0;
    init_s = s;
    cyc(1);
    chk(st, 8'h00);
    cyc(4);
    rstn = 1'b1;
    cyc(3);
    chk(pol, p);
  endtask

  task automatic t_polarity();
    cfg[0] = '{1'b1, SRC_LINE0, SENSE_LOW};
    t_reset(INIT_AUTO, 1'b0);
    cfg[0].sense = SENSE_HIGH;
    cyc(3);
    chk(pol, 1'b1);
    cfg[0] = '0;
    aux_s[1] = SENSE_FALL;
    aux_on = 4'h6;
    t_reset(INIT_AUTO, 1'b0);
    aux_on = 4'h0;
    t_reset(INIT_FALL, 1'b0);
    t_reset(INIT_RISE, 1'b1);
  endtask

  task automatic t_begin_off();
    chk(st.capture_allowed, 1'b0);
    pls(6);
    chk(st.capture_allowed, 1'b1);
    pick = PICK_CAP_ON;
    cyc(1);
    chk(sbit, 1'b1);
    pick = PICK_CAP_WAIT;
    cyc(1);
    chk(sbit, 1'b0);
    pls(7);
    cyc(2);
    chk(st.capture_allowed, 1'b0);
  endtask

  task automatic t_begin_trig();
    int n;
    cfg[0] = '{1'b1, SRC_HOST, SENSE_RISE};
    pls(6);
    cyc(2);
    chk(st.capture_arm_waiting, 1'b1);
    pls(1);
    cyc(3);
    chk(st.capture_allowed, 1'b0);
    pls(0);
    wait_val(3, 1'b1, 6, n);
    chk(n < 6, 1);
  endtask

  task automatic t_finish_line();
    int n;
    cfg[0] = '0;
    cfg[1] = '{1'b1, SRC_LINE0, SENSE_FALL};
    fork
      cat_trig_src_i.pulse(0, 600);
    join_none
    cyc(40);
    chk(st.capture_allowed, 1'b1);
    wait_val(3, 1'b0, 40, n);
    chk(n inside {[20:32]}, 1);
    cfg[1] = '0;
  endtask

  task automatic t_expose();
    int n;
    int d;
    int e;
    pls(6);
    cyc(3);
    chk(st.frame_arm_waiting, 1'b1);
    for (int i = 0; i < 2; i++) begin
      d = (i == 0) ? 2 : 0;
      e = (i == 0) ? 15 : 10;
      if (i == 0) begin
        len = {EXP_W'(12), EXP_W'(15), EXP_W'(11)};
      end else begin
        len = {3{EXP_W'(3)}};
        cfg[3] = '{1'b1, SRC_HOST, SENSE_RISE};
      end
      dly = DELAY_W'(d);
      starts = 0;
      ends = 0;
      pls(2);
      wait_val(2, 1'b1, d * 100 + 150, n);
      chk(n inside {[d * 100 - 100:d * 100 + 110]}, 1);
      wait_val(2, 1'b0, 2000, n);
      chk(n inside {[e * 100 - 100:e * 100 + 110]}, 1);
      if (i == 1) begin
        cyc(40);
        chk(starts, 0);
        chk(st.stream_hold_waiting, 1'b1);
        pls(3);
        wait_val(1, 1'b1, 10, n);
        chk(n < 10, 1);
      end
      drain();
      chk(ends, 1);
    end
    cfg[3] = '0;
  endtask

  task automatic t_overlap();
    int n;
    busy = 1'b1;
    pls(2);
    cyc(30);
    chk(st.light_integration_on, 1'b0);
    chk(st.frame_moving_data, 1'b1);
    ovl = 1'b1;
    pls(2);
    cyc(10);
    chk(st.light_integration_on, 1'b0);
    chk(st.frame_window_open, 1'b1);
    pls(8);
    wait_val(2, 1'b1, 5, n);
    chk(n < 5, 1);
    busy = 1'b0;
    drain();
  endtask

  task automatic t_pulse();
    int n;
    style = INTEG_PULSE;
    cfg[2] = '{1'b1, SRC_LINE1, SENSE_HIGH};
    fork
      cat_trig_src_i.pulse(1, 3000);
    join_none
    wait_val(2, 1'b1, 30, n);
    wait_val(2, 1'b0, 400, n);
    chk(n inside {[295:305]}, 1);
    drain();
  endtask

  task automatic t_burst();
    int n;
    pls(7);
    cyc(3);
    cfg[2].use_trig = 1'b0;
    style = INTEG_OFF;
    burst = 1'b1;
    btot = 8'h02;
    starts = 0;
    pls(6);
    cyc(3);
    n = 0;
    while (st.capture_allowed === 1'b1 && n < 9000) begin
      if (sstart === 1'b1) begin
        pls(9);
      end else begin
        cyc(1);
      end
      n++;
    end
    chk(n < 9000, 1);
    chk(starts, 2);
    cyc(2500);
    chk(starts, 2);
  endtask

  // Watchdog: the sequence needs some 13000 cycles, so 40000 means a hang.
  initial begin
    #400_000;
    num_errors++;
    wrap_up();
  end

  // Main sequence: defaults, reset for 5 cycles, then each scenario in turn.
  initial begin
    pv = '0;
    cfg = '0;
    cfg[2] = '{1'b1, SRC_HOST, SENSE_RISE};
    aux_s = '{default: SENSE_RISE};
    aux_on = '0;
    init_s = INIT_RISE;
    burst = 1'b0;
    btot = 8'h01;
    style = INTEG_PRESET;
    len = '0;
    dly = '0;
    per = 20'h0_0014;
    ovl = 1'b0;
    busy = 1'b0;
    pick = PICK_CAP_WAIT;
    rstn = 1'b0;
    cyc(5);
    rstn = 1'b1;
    cyc(3);
    t_polarity();
    t_begin_off();
    t_begin_trig();
    t_finish_line();
    t_expose();
    t_overlap();
    t_pulse();
    t_burst();
    wrap_up();
  end
endmodule // cat_seq_test
